/* hdl/ethernet_mac_pkg.sv */
package ethernet_mac_pkg;

  // Register byte offsets on the 32-bit slave port
  localparam logic [4:0] OFF_BUF_PORT = 5'h00;
  localparam logic [4:0] OFF_LAUNCH = 5'h04;
  localparam logic [4:0] OFF_COLL = 5'h08;
  localparam logic [4:0] OFF_CONFIG = 5'h0C;
  localparam logic [4:0] OFF_HASH_LO = 5'h10;
  localparam logic [4:0] OFF_HASH_HI = 5'h14;
  localparam logic [4:0] OFF_STATUS = 5'h18;

  // Field positions
  localparam int LAUNCH_START_BIT = 7;
  localparam int STAT_TXDONE_BIT = 8;
  localparam int STAT_HALT_BIT = 9;
  localparam int STAT_HASH_LSB = 10;
  localparam int RXS_CRC_BIT = 1;
  localparam int RXS_ALIGN_BIT = 2;
  localparam int RXS_SHORT_BIT = 3;
  localparam int RXS_OVF_BIT = 4;
  localparam int RXS_GOOD_BIT = 5;

  // Address filter select codes
  localparam logic [1:0] AF_NODE_BCAST = 2'h0;
  localparam logic [1:0] AF_HASH = 2'h1;
  localparam logic [1:0] AF_PROMISC = 2'h2;
  localparam logic [1:0] AF_REJECT = 2'h3;

  // Collision control codes
  localparam logic [7:0] COLL_HALT_RETRY = 8'h02;
  localparam logic [7:0] COLL_HALT_SKIP = 8'h03;
  localparam logic [7:0] COLL_AUTO_RETRY = 8'h06;
  localparam logic [7:0] COLL_AUTO_SKIP = 8'h07;

  // CRC constants, reflected IEEE 802.3 polynomial
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_PRESET = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  // Frame layout
  localparam int DA_BITS = 48;
  localparam int HASH_W = 6;
  localparam logic [4:0] FCS_LAST = 5'h1F;
  localparam int RX_HDR_BYTES = 4;
  localparam logic [10:0] MIN_FRAME_BYTES = 11'h040;
  localparam int LEN_W = 11;
  localparam int CNT_W = 7;
  localparam int TX_AW = 11;
  localparam int RX_AW = 12;

  // Reset values
  localparam logic [7:0] CFG_RESET = 8'h80;
  localparam logic [7:0] COLL_RESET = 8'h02;

  typedef struct packed {
    logic linkDisable;
    logic [2:0] spare;
    logic addrFilterSelHi;
    logic addrFilterSelLo;
    logic wordMode;
    logic byteOrder;
  } cfg_t;

  typedef struct packed {
    logic frameStart;
    logic frameEnd;
    logic bitValid;
    logic bitData;
  } rx_line_t;

  typedef struct packed {
    logic active;
    logic bitValid;
    logic bitData;
  } tx_line_t;

  typedef enum logic [2:0] {TX_IDLE, TX_LEN_LO, TX_LEN_HI, TX_DATA, TX_FCS, TX_HALT} tx_state_t;
  typedef enum logic [1:0] {RX_IDLE, RX_FRAME, RX_HDR} rx_state_t;

endpackage

/* hdl/ethernet_mac_packet_path.sv */
`timescale 1ns/1ps
// Summary of operation
// - Six-bit hash index from destination address CRC
// - Latch leftmost six CRC bits after address
// - Upper index bits pick byte, lower pick bit
// - Hash accept needs bit, multicast, no errors
// - Hash filtering only in filter mode 01
// - Broadcast accepted unless reject-all mode
// - Eight hash bytes hold 64 accept bits
// - Separate generator and checker CRC cores
// - Generator preset ones, starts at destination
// - Zero feedback, then shift CRC out
// - Checker includes FCS, compares with residue
// - Transmit packet preceded by 11-bit count
// - Four-byte header before each received packet
// - Status byte: bits 1-4 status, 5 good
// - Port write stores, advances transmit pointer
// - Port read returns, advances receive pointer
// - Word mode port is 16 bits only
// - Start bit launches transmit, reads one
// - Pending count decrements per sent packet
// - Collision register selects halt or continue
// - Codes 06 retry, 07 skip, 02/03 halt
// - Resume with 02 retry, 03 skip
// - Disable bit turns receiver, transmitter off
// - Byte order bit swaps port word bytes
module ethernet_mac_packet_path #(
  parameter int TX_DEPTH = 2048,
  parameter int RX_DEPTH = 4096
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsWriteData,
  input wire logic [3:0] avsByteEnable,
  output logic [31:0] avsReadData,
  output logic avsWaitRequest,
  input wire logic [47:0] nodeAddr,
  input wire ethernet_mac_pkg::rx_line_t rxLine,
  input wire logic txBitReady,
  input wire logic collision16,
  output ethernet_mac_pkg::tx_line_t txLine,
  output logic collCounterClear
);

  // One CRC step of the shift-right core; feedback taken from bit 0
  function automatic logic [31:0] crcStep(input logic [31:0] crc, input logic din);
    crcStep = (crc >> 1) ^ ((crc[0] ^ din) ? ethernet_mac_pkg::CRC_POLY : 32'h00000000);
  endfunction

  // Reset release through two flops
  logic rstMeta_q, rstSync_n;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      rstMeta_q <= 1'b0;
      rstSync_n <= 1'b0;
    end else begin
      rstMeta_q <= 1'b1;
      rstSync_n <= rstMeta_q;
    end
  end

  logic [7:0] txMem [TX_DEPTH];
  logic [7:0] rxMem [RX_DEPTH];
  ethernet_mac_pkg::cfg_t cfg_q;
  ethernet_mac_pkg::tx_state_t txState_q;
  ethernet_mac_pkg::rx_state_t rxState_q;
  logic ack_q;
  logic [7:0] coll_q;
  logic [63:0] hash_q;
  logic [ethernet_mac_pkg::CNT_W-1:0] launchCnt_q;
  logic [7:0] rxStatus_q;
  logic [ethernet_mac_pkg::HASH_W-1:0] hashIdx_q;
  logic txDone_q;
  logic [ethernet_mac_pkg::TX_AW-1:0] txWrPtr_q, txRdPtr_q, pktStart_q;
  logic [ethernet_mac_pkg::RX_AW-1:0] rxRdPtr_q, rxWrPtr_q, rxDataPtr_q;
  logic [ethernet_mac_pkg::LEN_W-1:0] txLen_q, bytesLeft_q, rxCount_q;
  logic [2:0] txBitIdx_q, rxBitIdx_q;
  logic [4:0] fcsCnt_q;
  logic [31:0] crcTx_q, crcRx_q;
  logic [5:0] daBits_q;
  logic [47:0] da_q;
  logic [7:0] rxByte_q;
  logic rxOvf_q;
  logic [1:0] hdrIdx_q;
  logic pktDone, allDone;

  // Bus access decode: one wait state, effects on the ack edge
  logic busReq, wrEn, rdEn, portWordOk, portWr, portRd, launchWr, collWr;
  assign busReq = avsRead | avsWrite;
  assign avsWaitRequest = busReq & ~ack_q;
  assign wrEn = avsWrite & ack_q;
  assign rdEn = avsRead & ack_q;
  assign portWordOk = cfg_q.wordMode ? (avsByteEnable[1:0] == 2'b11) : avsByteEnable[0];
  assign portWr = wrEn && avsAddress == ethernet_mac_pkg::OFF_BUF_PORT && portWordOk;
  assign portRd = rdEn && avsAddress == ethernet_mac_pkg::OFF_BUF_PORT && portWordOk;
  assign launchWr = wrEn && avsAddress == ethernet_mac_pkg::OFF_LAUNCH && avsByteEnable[0];
  assign collWr = wrEn && avsAddress == ethernet_mac_pkg::OFF_COLL && avsByteEnable[0];

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) ack_q <= 1'b0;
    else ack_q <= busReq & ~ack_q;
  end

  // Buffer port read word, bytes swapped by the order bit
  logic [ethernet_mac_pkg::RX_AW-1:0] rxRdNext;
  logic [15:0] portRdWord;
  assign rxRdNext = rxRdPtr_q + 1'b1;
  always_comb begin
    if (!cfg_q.wordMode) portRdWord = {8'h00, rxMem[rxRdPtr_q]};
    else if (cfg_q.byteOrder) portRdWord = {rxMem[rxRdPtr_q], rxMem[rxRdNext]};
    else portRdWord = {rxMem[rxRdNext], rxMem[rxRdPtr_q]};
  end

  // Read mux
  logic [31:0] rdValue;
  always_comb begin
    unique case (avsAddress)
      ethernet_mac_pkg::OFF_BUF_PORT: rdValue = {16'h0000, portRdWord};
      ethernet_mac_pkg::OFF_LAUNCH: rdValue = {24'h000000, 1'b1, launchCnt_q};
      ethernet_mac_pkg::OFF_COLL: rdValue = {24'h000000, coll_q};
      ethernet_mac_pkg::OFF_CONFIG: rdValue = {24'h000000, cfg_q};
      ethernet_mac_pkg::OFF_HASH_LO: rdValue = hash_q[31:0];
      ethernet_mac_pkg::OFF_HASH_HI: rdValue = hash_q[63:32];
      ethernet_mac_pkg::OFF_STATUS: rdValue = {16'h0000, hashIdx_q,
        txState_q == ethernet_mac_pkg::TX_HALT, txDone_q, rxStatus_q};
      default: rdValue = 32'h00000000;
    endcase
  end

  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) avsReadData <= 32'h00000000;
    else if (avsRead && !ack_q) avsReadData <= rdValue;
  end

  // Configuration, collision mode and hash table registers
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      cfg_q <= ethernet_mac_pkg::CFG_RESET;
      coll_q <= ethernet_mac_pkg::COLL_RESET;
      hash_q <= 64'h0000000000000000;
    end else begin
      if (wrEn && avsAddress == ethernet_mac_pkg::OFF_CONFIG && avsByteEnable[0])
        cfg_q <= avsWriteData[7:0];
      if (collWr) coll_q <= avsWriteData[7:0];
      for (int b = 0; b < 4; b++) begin
        if (wrEn && avsByteEnable[b] && avsAddress == ethernet_mac_pkg::OFF_HASH_LO)
          hash_q[8*b +: 8] <= avsWriteData[8*b +: 8];
        if (wrEn && avsByteEnable[b] && avsAddress == ethernet_mac_pkg::OFF_HASH_HI)
          hash_q[32 + 8*b +: 8] <= avsWriteData[8*b +: 8];
      end
    end
  end

  // Pending packet count
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) launchCnt_q <= '0;
    else if (launchWr) launchCnt_q <= avsWriteData[ethernet_mac_pkg::CNT_W-1:0];
    else if (pktDone && launchCnt_q != '0) launchCnt_q <= launchCnt_q - 1'b1;
  end

  // Transmit done flag, set wins over write-one clear
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) txDone_q <= 1'b1;
    else if (allDone) txDone_q <= 1'b1;
    else if (launchWr && avsWriteData[ethernet_mac_pkg::LAUNCH_START_BIT]) txDone_q <= 1'b0;
    else if (wrEn && avsAddress == ethernet_mac_pkg::OFF_STATUS && avsByteEnable[1] &&
             avsWriteData[ethernet_mac_pkg::STAT_TXDONE_BIT]) txDone_q <= 1'b0;
  end

  // Host writes into the transmit buffer
  always_ff @(posedge clk) begin
    if (portWr) begin
      if (!cfg_q.wordMode) begin
        txMem[txWrPtr_q] <= avsWriteData[7:0];
      end else begin
        txMem[txWrPtr_q] <= cfg_q.byteOrder ? avsWriteData[15:8] : avsWriteData[7:0];
        txMem[txWrPtr_q + 1'b1] <= cfg_q.byteOrder ? avsWriteData[7:0] : avsWriteData[15:8];
      end
    end
  end

  // Host side buffer pointers
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txWrPtr_q <= '0;
      rxRdPtr_q <= '0;
    end else begin
      if (allDone) txWrPtr_q <= '0;
      else if (portWr) txWrPtr_q <= txWrPtr_q + (cfg_q.wordMode ? 2'd2 : 2'd1);
      if (portRd) rxRdPtr_q <= rxRdPtr_q + (cfg_q.wordMode ? 2'd2 : 2'd1);
    end
  end

  // Transmit sequencer decisions
  logic txOnWire, txLast, startOk, collHit, resumeRetry, resumeSkip, doSkip, doRetry;
  logic [ethernet_mac_pkg::TX_AW-1:0] skipPtr;
  logic [7:0] txByte;
  assign txByte = txMem[txRdPtr_q];
  assign txOnWire = txState_q == ethernet_mac_pkg::TX_DATA || txState_q == ethernet_mac_pkg::TX_FCS;
  assign txLast = launchCnt_q <= 7'd1;
  assign startOk = launchWr && avsWriteData[ethernet_mac_pkg::LAUNCH_START_BIT] &&
                   avsWriteData[6:0] != 7'd0 && !cfg_q.linkDisable;
  assign collHit = collision16 && txOnWire;
  assign resumeRetry = collWr && txState_q == ethernet_mac_pkg::TX_HALT &&
                       avsWriteData[7:0] == ethernet_mac_pkg::COLL_HALT_RETRY;
  assign resumeSkip = collWr && txState_q == ethernet_mac_pkg::TX_HALT &&
                      avsWriteData[7:0] == ethernet_mac_pkg::COLL_HALT_SKIP;
  assign doRetry = resumeRetry || (collHit && coll_q == ethernet_mac_pkg::COLL_AUTO_RETRY);
  assign doSkip = resumeSkip || (collHit && coll_q == ethernet_mac_pkg::COLL_AUTO_SKIP);
  assign skipPtr = pktStart_q + 2'd2 + txLen_q;
  assign pktDone = doSkip || (txState_q == ethernet_mac_pkg::TX_FCS && txBitReady &&
                   fcsCnt_q == ethernet_mac_pkg::FCS_LAST);
  assign allDone = pktDone && txLast;
  assign collCounterClear = doRetry || doSkip;

  // Transmit sequencer
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      txState_q <= ethernet_mac_pkg::TX_IDLE;
      txRdPtr_q <= '0;
      pktStart_q <= '0;
      txLen_q <= '0;
      bytesLeft_q <= '0;
      txBitIdx_q <= 3'd0;
      fcsCnt_q <= 5'd0;
      crcTx_q <= ethernet_mac_pkg::CRC_PRESET;
      txLine <= '0;
    end else begin
      txLine.bitValid <= 1'b0;
      unique case (txState_q)
        ethernet_mac_pkg::TX_IDLE: begin
          if (startOk) begin
            txRdPtr_q <= '0;
            pktStart_q <= '0;
            txState_q <= ethernet_mac_pkg::TX_LEN_LO;
          end
        end
        ethernet_mac_pkg::TX_LEN_LO: begin
          txLen_q[7:0] <= txByte;
          txRdPtr_q <= txRdPtr_q + 1'b1;
          txState_q <= ethernet_mac_pkg::TX_LEN_HI;
        end
        ethernet_mac_pkg::TX_LEN_HI: begin
          txLen_q[10:8] <= txByte[2:0];
          bytesLeft_q <= {txByte[2:0], txLen_q[7:0]};
          txRdPtr_q <= txRdPtr_q + 1'b1;
          txBitIdx_q <= 3'd0;
          fcsCnt_q <= 5'd0;
          crcTx_q <= ethernet_mac_pkg::CRC_PRESET;
          txState_q <= {txByte[2:0], txLen_q[7:0]} == 11'd0 ?
                       ethernet_mac_pkg::TX_FCS : ethernet_mac_pkg::TX_DATA;
        end
        ethernet_mac_pkg::TX_DATA: begin
          if (txBitReady) begin
            txLine.bitValid <= 1'b1;
            txLine.bitData <= txByte[txBitIdx_q];
            crcTx_q <= crcStep(crcTx_q, txByte[txBitIdx_q]);
            txBitIdx_q <= txBitIdx_q + 1'b1;
            if (txBitIdx_q == 3'd7) begin
              txRdPtr_q <= txRdPtr_q + 1'b1;
              bytesLeft_q <= bytesLeft_q - 1'b1;
              if (bytesLeft_q == 11'd1) txState_q <= ethernet_mac_pkg::TX_FCS;
            end
          end
        end
        ethernet_mac_pkg::TX_FCS: begin
          if (txBitReady) begin
            txLine.bitValid <= 1'b1;
            txLine.bitData <= ~crcTx_q[0];
            crcTx_q <= crcTx_q >> 1;
            fcsCnt_q <= fcsCnt_q + 1'b1;
            if (fcsCnt_q == ethernet_mac_pkg::FCS_LAST) begin
              pktStart_q <= txRdPtr_q;
              txState_q <= txLast ? ethernet_mac_pkg::TX_IDLE : ethernet_mac_pkg::TX_LEN_LO;
            end
          end
        end
        ethernet_mac_pkg::TX_HALT: ;
        default: txState_q <= ethernet_mac_pkg::TX_IDLE;
      endcase
      // Collision outcomes override the normal step
      if (collHit && coll_q != ethernet_mac_pkg::COLL_AUTO_RETRY &&
          coll_q != ethernet_mac_pkg::COLL_AUTO_SKIP) begin
        txState_q <= ethernet_mac_pkg::TX_HALT;
      end else if (doRetry) begin
        txRdPtr_q <= pktStart_q;
        txState_q <= ethernet_mac_pkg::TX_LEN_LO;
      end else if (doSkip) begin
        txRdPtr_q <= skipPtr;
        pktStart_q <= skipPtr;
        txState_q <= txLast ? ethernet_mac_pkg::TX_IDLE : ethernet_mac_pkg::TX_LEN_LO;
      end
      if (cfg_q.linkDisable && txState_q != ethernet_mac_pkg::TX_IDLE) begin
        txState_q <= ethernet_mac_pkg::TX_IDLE;
      end
      txLine.active <= txOnWire;
    end
  end

  // Receive checker and address filter
  logic [31:0] crcRxNext;
  logic [47:0] daNext;
  logic rxOn, daDone, hashHit, bcast, ownHit, accept, crcErr, alignErr, shortErr;
  logic [7:0] rxStatusNew, rxByteNext;
  assign crcRxNext = crcStep(crcRx_q, rxLine.bitData);
  assign daNext = {rxLine.bitData, da_q[47:1]};
  assign rxByteNext = {rxLine.bitData, rxByte_q[7:1]};
  assign rxOn = rxState_q == ethernet_mac_pkg::RX_FRAME && rxLine.bitValid;
  assign daDone = rxOn && daBits_q == 6'(ethernet_mac_pkg::DA_BITS - 1);
  assign bcast = &da_q;
  assign ownHit = da_q == nodeAddr;
  assign hashHit = hash_q[hashIdx_q] && da_q[0];
  assign crcErr = crcRx_q != ethernet_mac_pkg::CRC_RESIDUE;
  assign alignErr = rxBitIdx_q != 3'd0;
  assign shortErr = rxCount_q < ethernet_mac_pkg::MIN_FRAME_BYTES;
  always_comb begin
    rxStatusNew = 8'h00;
    rxStatusNew[ethernet_mac_pkg::RXS_CRC_BIT] = crcErr;
    rxStatusNew[ethernet_mac_pkg::RXS_ALIGN_BIT] = alignErr;
    rxStatusNew[ethernet_mac_pkg::RXS_SHORT_BIT] = shortErr;
    rxStatusNew[ethernet_mac_pkg::RXS_OVF_BIT] = rxOvf_q;
    rxStatusNew[ethernet_mac_pkg::RXS_GOOD_BIT] = !(crcErr || alignErr || shortErr || rxOvf_q);
    unique case ({cfg_q.addrFilterSelHi, cfg_q.addrFilterSelLo})
      ethernet_mac_pkg::AF_NODE_BCAST: accept = ownHit || bcast;
      ethernet_mac_pkg::AF_HASH: accept = ownHit || bcast || hashHit;
      ethernet_mac_pkg::AF_PROMISC: accept = 1'b1;
      ethernet_mac_pkg::AF_REJECT: accept = 1'b0;
    endcase
    accept = accept && rxStatusNew[ethernet_mac_pkg::RXS_GOOD_BIT];
  end

  // Receive buffer write port: data bytes, then the header
  logic rxMemWe;
  logic [ethernet_mac_pkg::RX_AW-1:0] rxMemAddr;
  logic [7:0] rxMemData;
  always_comb begin
    rxMemWe = 1'b0;
    rxMemAddr = rxDataPtr_q;
    rxMemData = rxByteNext;
    if (rxState_q == ethernet_mac_pkg::RX_HDR) begin
      rxMemWe = 1'b1;
      rxMemAddr = rxWrPtr_q + hdrIdx_q;
      unique case (hdrIdx_q)
        2'd0: rxMemData = rxStatus_q;
        2'd1: rxMemData = 8'h00;
        2'd2: rxMemData = rxCount_q[7:0];
        2'd3: rxMemData = {5'h00, rxCount_q[10:8]};
      endcase
    end else if (rxOn && rxBitIdx_q == 3'd7 && !rxOvf_q && rxDataPtr_q + 1'b1 != rxRdPtr_q) begin
      rxMemWe = 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rxMemWe) rxMem[rxMemAddr] <= rxMemData;
  end

  // Receive sequencer
  always_ff @(posedge clk or negedge rstSync_n) begin
    if (!rstSync_n) begin
      rxState_q <= ethernet_mac_pkg::RX_IDLE;
      rxWrPtr_q <= '0;
      rxDataPtr_q <= '0;
      rxCount_q <= '0;
      rxBitIdx_q <= 3'd0;
      crcRx_q <= ethernet_mac_pkg::CRC_PRESET;
      daBits_q <= 6'd0;
      da_q <= '0;
      rxByte_q <= 8'h00;
      rxOvf_q <= 1'b0;
      hdrIdx_q <= 2'd0;
      hashIdx_q <= '0;
      rxStatus_q <= 8'h00;
    end else begin
      unique case (rxState_q)
        ethernet_mac_pkg::RX_IDLE: begin
          if (rxLine.frameStart && !cfg_q.linkDisable) begin
            rxState_q <= ethernet_mac_pkg::RX_FRAME;
            rxDataPtr_q <= rxWrPtr_q + 3'(ethernet_mac_pkg::RX_HDR_BYTES);
            rxCount_q <= '0;
            rxBitIdx_q <= 3'd0;
            crcRx_q <= ethernet_mac_pkg::CRC_PRESET;
            daBits_q <= 6'd0;
            rxOvf_q <= 1'b0;
          end
        end
        ethernet_mac_pkg::RX_FRAME: begin
          if (rxOn) begin
            crcRx_q <= crcRxNext;
            rxByte_q <= rxByteNext;
            rxBitIdx_q <= rxBitIdx_q + 1'b1;
            if (daBits_q != 6'(ethernet_mac_pkg::DA_BITS)) begin
              daBits_q <= daBits_q + 1'b1;
              da_q <= daNext;
            end
            if (daDone) hashIdx_q <= crcRxNext[31:26];
            if (rxBitIdx_q == 3'd7) begin
              if (rxMemWe) begin
                rxDataPtr_q <= rxDataPtr_q + 1'b1;
                rxCount_q <= rxCount_q + 1'b1;
              end else begin
                rxOvf_q <= 1'b1;
              end
            end
          end
          if (rxLine.frameEnd) begin
            rxStatus_q <= rxStatusNew;
            hdrIdx_q <= 2'd0;
            rxState_q <= accept ? ethernet_mac_pkg::RX_HDR : ethernet_mac_pkg::RX_IDLE;
          end
        end
        ethernet_mac_pkg::RX_HDR: begin
          hdrIdx_q <= hdrIdx_q + 1'b1;
          if (hdrIdx_q == 2'd3) begin
            rxWrPtr_q <= rxDataPtr_q;
            rxState_q <= ethernet_mac_pkg::RX_IDLE;
          end
        end
        default: rxState_q <= ethernet_mac_pkg::RX_IDLE;
      endcase
    end
  end

endmodule // ethernet_mac_packet_path

/* tb/ethernet_mac_packet_path_props.sv */
`timescale 1ns/1ps
module ethernet_mac_packet_path_props (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [4:0] avsAddress,
  input wire logic avsRead,
  input wire logic avsWrite,
  input wire logic [31:0] avsReadData,
  input wire logic avsWaitRequest,
  input wire ethernet_mac_pkg::tx_line_t txLine,
  input wire logic collCounterClear
);
  logic req;
  logic rdAck;
  // Request level and accepted read on the slave port
  assign req = avsRead || avsWrite;
  assign rdAck = avsRead && !avsWaitRequest;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!arst_n);
  chk_wait_first: assert property ($rose(req) |-> avsWaitRequest)
    else $error("waitrequest low at request start");
  chk_wait_answer: assert property (req && avsWaitRequest |=> !avsWaitRequest || !req)
    else $error("no answer one cycle after request");
  chk_wait_idle: assert property (!req |-> !avsWaitRequest)
    else $error("waitrequest without request");
  chk_wait_again: assert property (req && !avsWaitRequest ##1 req |-> avsWaitRequest)
    else $error("held request answered twice");
  chk_start_reads_one: assert property (rdAck && avsAddress == 5'h04 |-> avsReadData[7])
    else $error("start bit read back as zero");
  chk_unmapped_zero: assert property (rdAck && avsAddress == 5'h1C |-> avsReadData == 32'h0)
    else $error("unmapped read not zero");
  chk_read_hold: assert property (!$past(avsRead && avsWaitRequest) |-> $stable(avsReadData))
    else $error("read data changed without a read");
  chk_clear_pulse: assert property (collCounterClear |=> !collCounterClear)
    else $error("counter clear longer than one cycle");
  chk_bit_active: assert property (txLine.bitValid |-> txLine.active)
    else $error("bit sent outside data or check field");
  cover property (rdAck && avsAddress == 5'h04);
  cover property (txLine.bitValid);
  cover property (collCounterClear);
endmodule // ethernet_mac_packet_path_props

bind ethernet_mac_packet_path ethernet_mac_packet_path_props ethernet_mac_packet_path_props_inst (
  .clk(clk), .arst_n(arst_n), .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
  .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .txLine(txLine),
  .collCounterClear(collCounterClear));

/* tb/net_side_model.sv */
`timescale 1ns/1ps
module net_side_model (
  input wire logic clk,
  input wire logic slow,
  input wire ethernet_mac_pkg::tx_line_t txLine,
  output ethernet_mac_pkg::rx_line_t rxLine,
  output logic txBitReady
);
  logic txBits[$];
  initial begin
    rxLine = '0;
    txBitReady = 1'b0;
  end
  // Serializer pull, every cycle or every other cycle
  always @(posedge clk) begin
    txBitReady <= slow ? !txBitReady : 1'b1;
    if (txLine.bitValid)
      txBits.push_back(txLine.bitData);
  end
  // Frame from first destination bit, FCS included; data line toggles once idle
  task automatic send(input logic [7:0] f[$]);
    @(posedge clk);
    rxLine.frameStart <= 1'b1;
    foreach (f[i]) for (int k = 0; k < 8; k++) begin
      @(posedge clk);
      rxLine <= '{1'b0, 1'b0, 1'b1, f[i][k]};
    end
    @(posedge clk);
    rxLine <= '{1'b0, 1'b1, 1'b0, !rxLine.bitData};
    @(posedge clk);
    rxLine <= '{1'b0, 1'b0, 1'b0, !rxLine.bitData};
  endtask
endmodule // net_side_model

/* tb/testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic [4:0] avsAddress = 5'h00;
  logic avsRead = 1'b0;
  logic avsWrite = 1'b0;
  logic [31:0] avsWriteData = 32'h0;
  logic [3:0] avsByteEnable = 4'h0;
  logic collision16 = 1'b0;
  logic slow = 1'b1;
  logic clrSeen = 1'b0;
  logic [31:0] avsReadData;
  logic avsWaitRequest;
  logic txBitReady;
  logic collCounterClear;
  ethernet_mac_pkg::rx_line_t rxLine;
  ethernet_mac_pkg::tx_line_t txLine;
  logic [31:0] q;
  logic [47:0] got;
  logic [5:0] hix;
  logic [7:0] f[$];
  logic [4:0] regA[5] = '{5'h0C, 5'h08, 5'h04, 5'h18, 5'h1C};
  logic [31:0] regM[5] = '{32'hFF, 32'hFF, 32'hFF, 32'h300, 32'hFFFFFFFF};
  logic [31:0] regE[5] = '{32'h80, 32'h02, 32'h80, 32'h100, 32'h0};
  int err_total = 0;
  int check_count = 0;
  always #50 clk = !clk;
  // Catch the one-cycle collision counter clear
  always @(posedge clk) if (collCounterClear === 1'b1) clrSeen <= 1'b1;
  ethernet_mac_packet_path ethernet_mac_packet_path_inst (.clk(clk), .arst_n(arst_n),
    .avsAddress(avsAddress), .avsRead(avsRead), .avsWrite(avsWrite),
    .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable), .avsReadData(avsReadData),
    .avsWaitRequest(avsWaitRequest), .nodeAddr(48'h00000000AA02), .rxLine(rxLine),
    .txBitReady(txBitReady), .collision16(collision16), .txLine(txLine),
    .collCounterClear(collCounterClear));
  net_side_model net_side_model_inst (.clk(clk), .slow(slow), .txLine(txLine),
    .rxLine(rxLine), .txBitReady(txBitReady));
  // One slave access, held until waitrequest is sampled low
  task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    @(posedge clk);
    avsAddress <= a;
    avsWriteData <= d;
    avsByteEnable <= be;
    avsWrite <= w;
    avsRead <= !w;
    do @(posedge clk);
    while (avsWaitRequest !== 1'b0);
    q = avsReadData;
    avsWrite <= 1'b0;
    avsRead <= 1'b0;
  endtask
  task automatic chk(input logic [47:0] g, input logic [47:0] e);
    check_count++;
    if (g !== e) begin
      err_total++;
      $display("FAIL %0t got %h expected %h", $time, g, e);
    end
  endtask
  // Poll status until the given bit is set
  task automatic waitStat(input int b);
    do bus(1'b0, 5'h18, 32'h0, 4'hF);
    while (q[b] !== 1'b1);
  endtask
  // Reflected CRC register over the first n bytes, LSB first
  function automatic logic [31:0] crc(input logic [7:0] b[$], input int n);
    logic [31:0] c;
    c = ethernet_mac_pkg::CRC_PRESET;
    for (int i = 0; i < n; i++)
      for (int k = 0; k < 8; k++)
        c = (c >> 1) ^ ((c[0] ^ b[i][k]) ? ethernet_mac_pkg::CRC_POLY : 32'h0);
    return c;
  endfunction
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge clk);
    err_total++;
    print_verdict();
  end
  initial begin
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Reset values and an unmapped place
    foreach (regA[i]) begin
      bus(1'b0, regA[i], 32'h0, 4'hF);
      chk(q & regM[i], regE[i]);
    end
    // Hash table written and read while the link is off
    bus(1'b1, ethernet_mac_pkg::OFF_HASH_HI, 32'h5AF00F17, 4'hF);
    bus(1'b0, ethernet_mac_pkg::OFF_HASH_HI, 32'h0, 4'hF);
    chk(q, 32'h5AF00F17);
    bus(1'b1, ethernet_mac_pkg::OFF_CONFIG, 32'h0, 4'h1);
    // Two-byte packet, slow serializer
    f = '{8'h02, 8'h00, 8'hA5, 8'h3C};
    foreach (f[i]) bus(1'b1, ethernet_mac_pkg::OFF_BUF_PORT, {24'h0, f[i]}, 4'h1);
    bus(1'b1, ethernet_mac_pkg::OFF_LAUNCH, 32'h81, 4'h1);
    f = '{8'hA5, 8'h3C};
    while (net_side_model_inst.txBits.size() < 48) @(posedge clk);
    for (int i = 0; i < 48; i++) got[i] = net_side_model_inst.txBits[i];
    chk(got, {~crc(f, 2), f[1], f[0]});
    waitStat(8);
    bus(1'b0, ethernet_mac_pkg::OFF_LAUNCH, 32'h0, 4'hF);
    chk(q[7:0], 8'h80);
    // Halt on sixteenth collision, then resume by skipping
    slow <= 1'b0;
    f = '{8'h02, 8'h00, 8'hA5, 8'h3C};
    foreach (f[i]) bus(1'b1, ethernet_mac_pkg::OFF_BUF_PORT, {24'h0, f[i]}, 4'h1);
    bus(1'b1, ethernet_mac_pkg::OFF_LAUNCH, 32'h81, 4'h1);
    while (net_side_model_inst.txBits.size() < 50) @(posedge clk);
    collision16 <= 1'b1;
    @(posedge clk);
    collision16 <= 1'b0;
    waitStat(9);
    bus(1'b1, ethernet_mac_pkg::OFF_COLL, 32'h03, 4'h1);
    waitStat(8);
    chk(q[9:8], 2'b01);
    chk(clrSeen, 1'b1);
    // Broadcast frame received and read back with its header
    f.delete();
    for (int i = 0; i < 60; i++) f.push_back(i < 6 ? 8'hFF : 8'h00);
    hix = crc(f, 6) >> 26;
    q = ~crc(f, 60);
    for (int i = 0; i < 4; i++) f.push_back(q[8*i +: 8]);
    net_side_model_inst.send(f);
    waitStat(5);
    chk(q[15:0], {hix, 2'b01, 8'h20});
    f = '{8'h20, 8'h00, 8'h40, 8'h00, 8'hFF};
    foreach (f[i]) begin
      bus(1'b0, ethernet_mac_pkg::OFF_BUF_PORT, 32'h0, 4'h1);
      chk(q[7:0], f[i]);
    end
    // Multicast frame accepted only through its hash bit in mode 01
    f.delete();
    for (int i = 0; i < 60; i++) f.push_back(i == 0 ? 8'h01 : 8'h00);
    hix = crc(f, 6) >> 26;
    q = ~crc(f, 60);
    for (int i = 0; i < 4; i++) f.push_back(q[8*i +: 8]);
    bus(1'b1, ethernet_mac_pkg::OFF_CONFIG, 32'h80, 4'h1);
    bus(1'b1, hix[5] ? ethernet_mac_pkg::OFF_HASH_HI : ethernet_mac_pkg::OFF_HASH_LO,
        32'h1 << hix[4:0], 4'hF);
    bus(1'b1, ethernet_mac_pkg::OFF_CONFIG, 32'h04, 4'h1);
    net_side_model_inst.send(f);
    // Skip the rest of the first stored frame, then read the new header
    repeat (63) bus(1'b0, ethernet_mac_pkg::OFF_BUF_PORT, 32'h0, 4'h1);
    bus(1'b0, ethernet_mac_pkg::OFF_BUF_PORT, 32'h0, 4'h1);
    chk(q[7:0], 8'h20);
    bus(1'b0, ethernet_mac_pkg::OFF_STATUS, 32'h0, 4'hF);
    chk(q[15:10], hix);
    print_verdict();
  end
endmodule // testbench
